// *** logic/csr_defs.vh ***
// register numbers, field positions, reset values and operation codes for the system register group
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// register numbers (register file addresses)
`define CSR_ADDR_TWIN_HI      8'he9
`define CSR_ADDR_PAGE_SEL     8'hea
`define CSR_ADDR_MODE         8'heb
`define CSR_ADDR_USP_HIGH     8'hec
`define CSR_ADDR_USP_LOW      8'hed
`define CSR_ADDR_SSP_HIGH     8'hee
`define CSR_ADDR_SSP_LOW      8'hef

// field masks of the pointer registers (forced-zero bits cleared)
`define CSR_TWIN_HI_MASK      8'hfc
`define CSR_PAGE_SEL_MASK     8'hfc
`define CSR_PTR_MODE_BIT      2

// mode register fields
`define CSR_MODE_RESET        8'he0
`define CSR_MODE_SYS_STK_BIT  7
`define CSR_MODE_USR_STK_BIT  6
`define CSR_MODE_OSC_HALF_DIVIDE_BIT     5
`define CSR_MODE_PRS_HI       4
`define CSR_MODE_PRS_LO       2
`define CSR_MODE_BRQ_BIT      1
`define CSR_MODE_FLOAT_BIT    0

// stack operation codes
`define CSR_STK_NONE          3'h0
`define CSR_STK_PUSH_B        3'h1
`define CSR_STK_PUSH_W        3'h2
`define CSR_STK_POP_B         3'h3
`define CSR_STK_POP_W         3'h4

// pointer instruction codes
`define CSR_PTR_NONE          2'h0
`define CSR_PTR_SINGLE        2'h1
`define CSR_PTR_TWIN_LOW      2'h2
`define CSR_PTR_TWIN_HIGH     2'h3

// sequencer states, one-hot
`define CSR_ST_IDLE           4'h1
`define CSR_ST_PC_LO          4'h2
`define CSR_ST_PC_HI          4'h4
`define CSR_ST_EXTRA          4'h8

`endif

// *** logic/csr_stack_ptr.v ***
// one 16-bit stack pointer pair with pre-decrement push and post-increment pop
`timescale 1ns/1ps
`default_nettype none
`include "csr_defs.vh"

module csr_stack_ptr (
    input  wire        clk,
    input  wire        rstn,
    input  wire        wr_hi,
    input  wire        wr_lo,
    input  wire [7:0]  wr_data,
    input  wire [2:0]  stk_op,
    input  wire        internal,
    output reg  [15:0] ptr_q,
    output reg  [15:0] addr_q
);

    // =====================================================================
    // next pointer and access address
    // =====================================================================
    reg  [15:0] ptr_d;
    reg  [15:0] addr_d;
    reg  [15:0] dec_val;

    // push decrements first and writes at the new value; pop reads the old value
    always @* begin
        dec_val = 16'h0000;
        ptr_d   = ptr_q;
        addr_d  = addr_q;
        case (stk_op)
            `CSR_STK_PUSH_B: begin
                dec_val = ptr_q - 16'h0001;
                ptr_d   = dec_val;
                addr_d  = dec_val;
            end
            `CSR_STK_PUSH_W: begin
                dec_val = ptr_q - 16'h0002;
                ptr_d   = dec_val;
                addr_d  = dec_val;
            end
            `CSR_STK_POP_B: begin
                addr_d  = ptr_q;
                ptr_d   = ptr_q + 16'h0001;
            end
            `CSR_STK_POP_W: begin
                addr_d  = ptr_q;
                ptr_d   = ptr_q + 16'h0002;
            end
            default: begin
                ptr_d   = ptr_q;
            end
        endcase
        // in-file stacks wrap in the low byte; the high byte stays put
        if (internal && stk_op != `CSR_STK_NONE) begin
            ptr_d[15:8]  = ptr_q[15:8];
            addr_d[15:8] = 8'h00;
        end
        if (wr_hi) begin
            ptr_d[15:8] = wr_data;
        end
        if (wr_lo) begin
            ptr_d[7:0] = wr_data;
        end
    end

    // no defined value is promised, zero keeps simulation clean
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q  <= 16'h0000;
            addr_q <= 16'h0000;
        end else begin
            ptr_q  <= ptr_d;
            addr_q <= addr_d;
        end
    end

endmodule // csr_stack_ptr
`default_nettype wire

// *** logic/csr_sys_regs.v ***
// system register group: twin pointer, page select, mode register, stack pointers
//
// Operation
// - twin pointer bits 7:3 hold block
// - pointer mode bit: twin sets, single clears
// - twin pointer bits 1:0 read zero
// - page select maps page into group F
// - page number in bits 7:2, 1:0 zero
// - page select never pushed on interrupt
// - mode bit 7: system stack location
// - mode bit 6: user stack location
// - mode bit 5 halves oscillator input
// - mode bits 4:2 prescale core clock 1-8
// - mode bit 1 enables bus request
// - mode bit 0 floats external bus lines
// - float leaves general I/O lines alone
// - push pre-decrements, pop post-increments pointer
// - pop leaves stack contents unchanged
// - interrupt pushes pc, flags, maybe segment
// - near call pushes pc, segment call both
// - user variant selects user stack pointer
// - in-file stack uses low byte only
// - system stack pointer at 238 and 239
`timescale 1ns/1ps
`default_nettype none
`include "csr_defs.vh"

module csr_sys_regs (
    input  wire        clk,
    input  wire        rstn,
    // register access from the instruction executor
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_q,
    output reg         reg_hit_q,
    // pointer instructions
    input  wire [1:0]  ptr_instr,
    input  wire [4:0]  ptr_block,
    input  wire        set_page_instr,
    input  wire [5:0]  page_arg,
    // stack instructions
    input  wire        push_req,
    input  wire        pop_req,
    input  wire        stk_word,
    input  wire        stk_user,
    // automatic stacking sequences
    input  wire        irq_entry,
    input  wire        near_call,
    input  wire        seg_call,
    input  wire        code_segment_save_enable,
    input  wire [15:0] pc_value,
    input  wire [7:0]  flag_value,
    input  wire [7:0]  code_segment_reg,
    // stack memory side
    output reg         stk_we_q,
    output reg         stk_re_q,
    output reg         stk_in_file_q,
    output reg  [15:0] stk_addr_q,
    output reg  [7:0]  stk_wdata_q,
    output reg         seq_busy_q,
    // mode outputs
    output reg  [4:0]  block_number_field_q,
    output reg         pointer_mode_select_q,
    output reg  [5:0]  page_number_field_q,
    output reg         osc_half_divide_q,
    output reg  [2:0]  core_clock_prescale_q,
    output reg         bus_request_grant_q,
    output reg  [7:0]  port_oe_q,
    output reg         strobe_oe_q,
    // pins and port configuration
    input  wire        bus_request_pin_n,
    input  wire        bus_request_present,
    input  wire [7:0]  port_is_address,
    input  wire [7:0]  port_drive_req,
    input  wire        strobe_drive_req
);

    // =====================================================================
    // synchronisers for the pin
    // =====================================================================
    reg        bus_request_pin_s1_q;
    reg        bus_request_pin_s2_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_request_pin_s1_q <= 1'b1;
            bus_request_pin_s2_q <= 1'b1;
        end else begin
            bus_request_pin_s1_q <= bus_request_pin_n;
            bus_request_pin_s2_q <= bus_request_pin_s1_q;
        end
    end

    // =====================================================================
    // stored registers
    // =====================================================================
    reg  [7:0] twin_pointer_high_block_q;
    reg  [7:0] peripheral_page_select_q;
    reg  [7:0] core_operating_mode_q;

    wire wr_twin = reg_wr && (reg_addr == `CSR_ADDR_TWIN_HI);
    wire wr_page = reg_wr && (reg_addr == `CSR_ADDR_PAGE_SEL);
    wire wr_mode = reg_wr && (reg_addr == `CSR_ADDR_MODE);
    wire wr_usph = reg_wr && (reg_addr == `CSR_ADDR_USP_HIGH);
    wire wr_uspl = reg_wr && (reg_addr == `CSR_ADDR_USP_LOW);
    wire wr_ssph = reg_wr && (reg_addr == `CSR_ADDR_SSP_HIGH);
    wire wr_sspl = reg_wr && (reg_addr == `CSR_ADDR_SSP_LOW);

    // instructions beat a plain register write in the same cycle
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            twin_pointer_high_block_q <= 8'h00;
            peripheral_page_select_q  <= 8'h00;
            core_operating_mode_q     <= `CSR_MODE_RESET;
        end else begin
            if (ptr_instr == `CSR_PTR_TWIN_HIGH) begin
                twin_pointer_high_block_q <= {ptr_block, 3'h4};
            end else if (ptr_instr == `CSR_PTR_TWIN_LOW) begin
                twin_pointer_high_block_q[`CSR_PTR_MODE_BIT] <= 1'b1;
            end else if (ptr_instr == `CSR_PTR_SINGLE) begin
                twin_pointer_high_block_q[`CSR_PTR_MODE_BIT] <= 1'b0;
            end else if (wr_twin) begin
                twin_pointer_high_block_q <= reg_wdata & `CSR_TWIN_HI_MASK;
            end
            // page select stays until changed; nothing here saves it
            if (set_page_instr) begin
                peripheral_page_select_q <= {page_arg, 2'h0};
            end else if (wr_page) begin
                peripheral_page_select_q <= reg_wdata & `CSR_PAGE_SEL_MASK;
            end
            if (wr_mode) begin
                core_operating_mode_q <= reg_wdata;
            end
        end
    end

    wire sys_internal = core_operating_mode_q[`CSR_MODE_SYS_STK_BIT];
    wire usr_internal = core_operating_mode_q[`CSR_MODE_USR_STK_BIT];

    // =====================================================================
    // automatic stacking sequencer
    // =====================================================================
    // pushes go low byte first so a word lands high byte at lower address
    reg  [3:0] state_q;
    reg  [3:0] state_d;
    reg        extra_q;
    reg  [7:0] extra_data_q;
    reg  [15:0] pc_hold_q;

    wire start_irq  = irq_entry && (state_q == `CSR_ST_IDLE);
    wire start_call = (near_call || seg_call) && (state_q == `CSR_ST_IDLE) && !irq_entry;

    always @* begin
        state_d = state_q;
        case (state_q)
            `CSR_ST_IDLE: begin
                if (start_irq || start_call) begin
                    state_d = `CSR_ST_PC_LO;
                end
            end
            `CSR_ST_PC_LO: begin
                state_d = `CSR_ST_PC_HI;
            end
            `CSR_ST_PC_HI: begin
                state_d = extra_q ? `CSR_ST_EXTRA : `CSR_ST_IDLE;
            end
            `CSR_ST_EXTRA: begin
                state_d = seg_pending_q ? `CSR_ST_EXTRA : `CSR_ST_IDLE;
            end
            default: begin
                state_d = `CSR_ST_IDLE;
            end
        endcase
    end

    // the extra byte is flags on interrupt, plus segment when asked, or segment on a segment call; kept one byte wide each
    reg        seg_pending_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q       <= `CSR_ST_IDLE;
            extra_q       <= 1'b0;
            extra_data_q  <= 8'h00;
            pc_hold_q     <= 16'h0000;
            seg_pending_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (start_irq) begin
                pc_hold_q     <= pc_value;
                extra_q       <= 1'b1;
                extra_data_q  <= flag_value;
                seg_pending_q <= code_segment_save_enable;
            end else if (start_call) begin
                pc_hold_q     <= pc_value;
                extra_q       <= seg_call;
                extra_data_q  <= code_segment_reg;
                seg_pending_q <= 1'b0;
            end else if (state_q == `CSR_ST_EXTRA && seg_pending_q) begin
                // one more pass for the segment byte after the flags
                extra_data_q  <= code_segment_reg;
                seg_pending_q <= 1'b0;
            end
            if (state_q == `CSR_ST_PC_HI && !extra_q) begin
                extra_q <= 1'b0;
            end
        end
    end

    wire seg_again = (state_q == `CSR_ST_EXTRA) && seg_pending_q;
    wire seq_push  = (state_q != `CSR_ST_IDLE) || seg_again;

    // =====================================================================
    // stack pointer pairs
    // =====================================================================
    reg  [2:0] sys_op;
    reg  [2:0] usr_op;
    reg  [7:0] push_byte;

    // explicit instructions for either stack are dropped, not held, while the sequencer pushes
    always @* begin
        sys_op    = `CSR_STK_NONE;
        usr_op    = `CSR_STK_NONE;
        push_byte = reg_wdata;
        if (seq_push) begin
            sys_op = `CSR_STK_PUSH_B;
            case (state_q)
                `CSR_ST_PC_LO: push_byte = pc_hold_q[7:0];
                `CSR_ST_PC_HI: push_byte = pc_hold_q[15:8];
                `CSR_ST_EXTRA: push_byte = extra_data_q;
                default:       push_byte = extra_data_q;
            endcase
        end else if (push_req) begin
            if (stk_user) begin
                usr_op = stk_word ? `CSR_STK_PUSH_W : `CSR_STK_PUSH_B;
            end else begin
                sys_op = stk_word ? `CSR_STK_PUSH_W : `CSR_STK_PUSH_B;
            end
        end else if (pop_req) begin
            if (stk_user) begin
                usr_op = stk_word ? `CSR_STK_POP_W : `CSR_STK_POP_B;
            end else begin
                sys_op = stk_word ? `CSR_STK_POP_W : `CSR_STK_POP_B;
            end
        end
    end

    wire [15:0] ssp_val;
    wire [15:0] ssp_addr;
    wire [15:0] usp_val;
    wire [15:0] usp_addr;

    csr_stack_ptr u_sys_ptr (
        .clk      (clk),
        .rstn     (rstn),
        .wr_hi    (wr_ssph),
        .wr_lo    (wr_sspl),
        .wr_data  (reg_wdata),
        .stk_op   (sys_op),
        .internal (sys_internal),
        .ptr_q    (ssp_val),
        .addr_q   (ssp_addr)
    );

    csr_stack_ptr u_usr_ptr (
        .clk      (clk),
        .rstn     (rstn),
        .wr_hi    (wr_usph),
        .wr_lo    (wr_uspl),
        .wr_data  (reg_wdata),
        .stk_op   (usr_op),
        .internal (usr_internal),
        .ptr_q    (usp_val),
        .addr_q   (usp_addr)
    );

    // =====================================================================
    // stack memory strobes, aligned with the pointer address register
    // =====================================================================
    reg        use_user_q;
    // a pop only reads; nothing ever clears the vacated locations
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stk_we_q      <= 1'b0;
            stk_re_q      <= 1'b0;
            stk_wdata_q   <= 8'h00;
            use_user_q    <= 1'b0;
            stk_in_file_q <= 1'b1;
            seq_busy_q    <= 1'b0;
        end else begin
            stk_we_q      <= (sys_op == `CSR_STK_PUSH_B) || (sys_op == `CSR_STK_PUSH_W)
                           || (usr_op == `CSR_STK_PUSH_B) || (usr_op == `CSR_STK_PUSH_W);
            stk_re_q      <= (sys_op == `CSR_STK_POP_B) || (sys_op == `CSR_STK_POP_W)
                           || (usr_op == `CSR_STK_POP_B) || (usr_op == `CSR_STK_POP_W);
            stk_wdata_q   <= push_byte;
            use_user_q    <= (usr_op != `CSR_STK_NONE);
            stk_in_file_q <= (usr_op != `CSR_STK_NONE) ? usr_internal : sys_internal;
            seq_busy_q    <= (state_d != `CSR_ST_IDLE) || seg_again;
        end
    end

    always @* begin
        stk_addr_q = use_user_q ? usp_addr : ssp_addr;
    end

    // =====================================================================
    // read path
    // =====================================================================
    reg  [7:0] rd_d;
    reg        hit_d;
    always @* begin
        hit_d = 1'b1;
        case (reg_addr)
            `CSR_ADDR_TWIN_HI:  rd_d = twin_pointer_high_block_q & `CSR_TWIN_HI_MASK;
            `CSR_ADDR_PAGE_SEL: rd_d = peripheral_page_select_q & `CSR_PAGE_SEL_MASK;
            `CSR_ADDR_MODE:     rd_d = core_operating_mode_q;
            `CSR_ADDR_USP_HIGH: rd_d = usp_val[15:8];
            `CSR_ADDR_USP_LOW:  rd_d = usp_val[7:0];
            `CSR_ADDR_SSP_HIGH: rd_d = ssp_val[15:8];
            `CSR_ADDR_SSP_LOW:  rd_d = ssp_val[7:0];
            default: begin
                rd_d  = 8'h00;
                hit_d = 1'b0;
            end
        endcase
    end

    // =====================================================================
    // control outputs
    // =====================================================================
    // address lines float only when the float bit is set; i/o lines keep drive
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q           <= 8'h00;
            reg_hit_q             <= 1'b0;
            block_number_field_q  <= 5'h00;
            pointer_mode_select_q <= 1'b0;
            page_number_field_q   <= 6'h00;
            osc_half_divide_q     <= 1'b1;
            core_clock_prescale_q <= 3'h0;
            bus_request_grant_q   <= 1'b0;
            port_oe_q             <= 8'h00;
            strobe_oe_q           <= 1'b0;
        end else begin
            reg_rdata_q           <= reg_rd ? rd_d : 8'h00;
            reg_hit_q             <= reg_rd && hit_d;
            block_number_field_q  <= twin_pointer_high_block_q[7:3];
            pointer_mode_select_q <= twin_pointer_high_block_q[`CSR_PTR_MODE_BIT];
            page_number_field_q   <= peripheral_page_select_q[7:2];
            osc_half_divide_q     <= core_operating_mode_q[`CSR_MODE_OSC_HALF_DIVIDE_BIT];
            core_clock_prescale_q <= core_operating_mode_q[`CSR_MODE_PRS_HI:`CSR_MODE_PRS_LO];
            bus_request_grant_q   <= core_operating_mode_q[`CSR_MODE_BRQ_BIT]
                                   && bus_request_present && !bus_request_pin_s2_q;
            if (core_operating_mode_q[`CSR_MODE_FLOAT_BIT]) begin
                port_oe_q   <= port_drive_req & ~port_is_address;
                strobe_oe_q <= 1'b0;
            end else begin
                port_oe_q   <= port_drive_req;
                strobe_oe_q <= strobe_drive_req;
            end
        end
    end

endmodule // csr_sys_regs
`default_nettype wire

// *** sim/csr_sys_regs_assertions.sv ***
// concurrent checks on the ports of the system register group
`timescale 1ns/1ps
`default_nettype none
`include "csr_defs.vh"
// ====================
// port checker
module csr_sys_regs_chk (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata_q,
    input wire logic [1:0] ptr_instr,
    input wire logic       set_page_instr,
    input wire logic [5:0] page_arg,
    input wire logic       push_req,
    input wire logic       pop_req,
    input wire logic       irq_entry,
    input wire logic       near_call,
    input wire logic       seg_call,
    input wire logic       code_segment_save_enable,
    input wire logic       stk_we_q,
    input wire logic       stk_re_q,
    input wire logic       seq_busy_q,
    input wire logic       pointer_mode_select_q,
    input wire logic [5:0] page_number_field_q,
    input wire logic [7:0] port_oe_q,
    input wire logic [7:0] port_is_address,
    input wire logic [7:0] port_drive_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // nothing else owns the stack this edge
    wire quiet = !irq_entry && !near_call && !seg_call && !seq_busy_q;

    a_twin_low_zero: assert property (reg_rd && reg_addr == `CSR_ADDR_TWIN_HI |=>
        reg_rdata_q[1:0] == 2'h0) else $error("twin pointer low bits read nonzero");
    a_twin_sets_mode: assert property ((ptr_instr == `CSR_PTR_TWIN_LOW ||
        ptr_instr == `CSR_PTR_TWIN_HIGH) ##1 (ptr_instr == `CSR_PTR_NONE && !reg_wr)
        |=> pointer_mode_select_q) else $error("twin instruction left single mode");
    a_single_clears: assert property (ptr_instr == `CSR_PTR_SINGLE ##1
        ptr_instr == `CSR_PTR_NONE |=> !pointer_mode_select_q) else $error("single mode not set");
    a_page_load: assert property (set_page_instr ##1 (!set_page_instr && !reg_wr) |=>
        page_number_field_q == $past(page_arg, 2)) else $error("page number not loaded");
    a_push_strobe: assert property (push_req && quiet |=> stk_we_q && !stk_re_q)
        else $error("push gave no write strobe");
    a_pop_no_write: assert property (pop_req && !push_req && quiet |=>
        stk_re_q && !stk_we_q) else $error("pop strobes wrong");
    a_irq_four: assert property (irq_entry && !seq_busy_q && code_segment_save_enable |->
        ##2 stk_we_q [*4] ##1 !stk_we_q) else $error("interrupt entry byte count wrong");
    a_near_two: assert property (near_call && !irq_entry && !seq_busy_q &&
        !code_segment_save_enable |-> ##2 stk_we_q [*2] ##1 !stk_we_q) else $error("near call count");
    a_io_lines_kept: assert property ($past(rstn) |-> (port_oe_q & ~$past(port_is_address))
        == ($past(port_drive_req) & ~$past(port_is_address))) else $error("io line enable hit");

    // main scenarios seen
    c_irq: cover property (irq_entry ##1 stk_we_q);
    c_seg: cover property (seg_call ##1 stk_we_q);
    c_pop: cover property (pop_req ##1 stk_re_q);
endmodule // csr_sys_regs_chk

bind csr_sys_regs csr_sys_regs_chk u_chk (.*);
`default_nettype wire

// *** sim/csr_testbench.sv ***
// self-checking bench for the system register group
`timescale 1ns/1ps
`default_nettype none
`include "csr_defs.vh"
// ====================
// bench top
module testbench;
    logic        clk, rstn, reg_wr, reg_rd, set_page_instr, push_req, pop_req, stk_word, rhit;
    logic        stk_user, irq_entry, near_call, seg_call, code_segment_save_enable;
    logic        bus_request_pin_n, bus_request_present, strobe_drive_req, reg_hit_q;
    logic [7:0]  reg_addr, reg_wdata, flag_value, code_segment_reg, port_is_address, rdat;
    logic [7:0]  port_drive_req, reg_rdata_q, stk_wdata_q, port_oe_q;
    logic [1:0]  ptr_instr;
    logic [4:0]  ptr_block, block_number_field_q;
    logic [5:0]  page_arg, page_number_field_q;
    logic [15:0] pc_value, stk_addr_q;
    logic [2:0]  core_clock_prescale_q;
    logic        stk_we_q, stk_re_q, stk_in_file_q, seq_busy_q, strobe_oe_q;
    logic        pointer_mode_select_q, osc_half_divide_q, bus_request_grant_q;
    int          fails = 0;
    int          compares = 0;
    // rows: address, write data, read-back, hit
    logic [24:0] rows [8] = '{{8'he9, 8'hff, 8'hfc, 1'b1}, {8'hea, 8'hff, 8'hfc, 1'b1},
        {8'heb, 8'h55, 8'h55, 1'b1}, {8'hec, 8'ha5, 8'ha5, 1'b1}, {8'hed, 8'h5a, 8'h5a, 1'b1},
        {8'hee, 8'h12, 8'h12, 1'b1}, {8'hef, 8'h34, 8'h34, 1'b1}, {8'h00, 8'hff, 8'h00, 1'b0}};

    csr_sys_regs dut (.*);

    // ====================
    // tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands one cycle only, so it is caught at the following low phase
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rdat = reg_rdata_q;
        rhit = reg_hit_q;
    endtask
    // one-cycle pulse; two idle edges first so a finished sequence has dropped busy
    task automatic op(input int k, input logic w = 1'b0, input logic u = 1'b0,
                      input logic [1:0] pi = 2'h0);
        repeat (2) @(posedge clk);
        stk_word <= w;
        stk_user <= u;
        case (k)
            0: push_req <= 1'b1;
            1: pop_req <= 1'b1;
            2: irq_entry <= 1'b1;
            3: near_call <= 1'b1;
            4: seg_call <= 1'b1;
            5: set_page_instr <= 1'b1;
            default: ptr_instr <= pi;
        endcase
        @(posedge clk);
        {push_req, pop_req, irq_entry, near_call, seg_call, set_page_instr} <= 6'h00;
        ptr_instr <= 2'h0;
        @(negedge clk);
    endtask
    task automatic seqchk(input int n, input logic [31:0] d, input logic [15:0] a0);
        @(negedge clk); // first byte lands one edge after the start
        for (int i = 0; i < n; i++) begin
            chk(stk_we_q, 16'h1);
            chk(seq_busy_q, {15'h0000, i < n - 1});
            chk(stk_addr_q, a0 - i[15:0]);
            chk(stk_wdata_q, d[8*i +: 8]);
            @(negedge clk);
        end
        chk(stk_we_q, 16'h0);
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ====================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25.0 * 4000);
        fails++;
        summarize();
    end

    // ====================
    // main sequence
    initial begin
        {reg_wr, reg_rd, set_page_instr, push_req, pop_req, stk_word, stk_user} = 7'h00;
        {irq_entry, near_call, seg_call, code_segment_save_enable, bus_request_pin_n} = 5'h01;
        {bus_request_present, strobe_drive_req, reg_addr, reg_wdata, ptr_instr} = 20'hc0000;
        ptr_block = 5'h1b;
        page_arg = 6'h2a;
        pc_value = 16'hbeef;
        flag_value = 8'h5c;
        code_segment_reg = 8'h21;
        port_is_address = 8'h1f;
        port_drive_req = 8'hff;
        rstn = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(`CSR_ADDR_MODE);
        chk(rdat, 16'he0);
        chk(osc_half_divide_q, 16'h1);
        chk(stk_in_file_q, 16'h1);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i][24:17], rows[i][16:9]);
            rd(rows[i][24:17]);
            chk(rdat, rows[i][8:1]);
            chk(rhit, rows[i][0]);
        end
        $display("register table test done");
        chk(core_clock_prescale_q, 16'h5);
        chk(osc_half_divide_q, 16'h0);
        chk(port_oe_q, 16'he0);
        chk(strobe_oe_q, 16'h0);
        wr(`CSR_ADDR_MODE, 8'h3e);
        bus_request_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(bus_request_grant_q, 16'h1);
        chk({core_clock_prescale_q, osc_half_divide_q, port_oe_q}, 16'h0fff);
        chk(strobe_oe_q, 16'h1);
        wr(`CSR_ADDR_MODE, 8'h3c);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(bus_request_grant_q, 16'h0);
        $display("mode test done");
        op(6, 1'b0, 1'b0, `CSR_PTR_TWIN_HIGH);
        rd(`CSR_ADDR_TWIN_HI);
        chk(rdat, 16'hdc);
        chk(block_number_field_q, 16'h1b);
        op(6, 1'b0, 1'b0, `CSR_PTR_SINGLE);
        rd(`CSR_ADDR_TWIN_HI);
        chk(rdat, 16'hd8);
        op(6, 1'b0, 1'b0, `CSR_PTR_TWIN_LOW);
        rd(`CSR_ADDR_TWIN_HI);
        chk(rdat, 16'hdc);
        op(5);
        rd(`CSR_ADDR_PAGE_SEL);
        rd(`CSR_ADDR_PAGE_SEL);
        chk(rdat, 16'ha8);
        chk(page_number_field_q, 16'h2a);
        $display("pointer test done");
        // stacks kept out of the system group and never holding their own pointer
        wr(`CSR_ADDR_MODE, 8'h00);
        wr(`CSR_ADDR_SSP_LOW, 8'h34);
        op(0);
        chk({stk_we_q, stk_addr_q[14:0]}, 16'h9233);
        op(0, 1'b1);
        chk(stk_addr_q, 16'h1231);
        op(1, 1'b1);
        chk({stk_re_q, stk_we_q, stk_addr_q[13:0]}, 16'h9231);
        op(1);
        chk(stk_addr_q, 16'h1233);
        rd(`CSR_ADDR_SSP_LOW);
        chk(rdat, 16'h34);
        op(0, 1'b0, 1'b1);
        chk(stk_addr_q, 16'ha559);
        wr(`CSR_ADDR_MODE, 8'hc0);
        wr(`CSR_ADDR_SSP_LOW, 8'h40);
        op(0);
        chk({stk_in_file_q, stk_addr_q[14:0]}, 16'h803f);
        $display("stack test done");
        wr(`CSR_ADDR_MODE, 8'h00);
        wr(`CSR_ADDR_SSP_LOW, 8'h34);
        code_segment_save_enable <= 1'b1;
        op(2);
        seqchk(4, 32'h215cbeef, 16'h1233);
        rd(`CSR_ADDR_PAGE_SEL);
        chk(rdat, 16'ha8);
        @(posedge clk);
        code_segment_save_enable <= 1'b0;
        pc_value <= 16'h1357;
        code_segment_reg <= 8'h3e;
        page_arg <= 6'h15;
        op(4);
        seqchk(3, 32'h003e1357, 16'h122f);
        op(3);
        seqchk(2, 32'h00001357, 16'h122c);
        op(5);
        rd(`CSR_ADDR_PAGE_SEL);
        chk(rdat, 16'h54);
        $display("sequence test done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
